/* File: hw/sep_pkg.sv */
// constants and types shared by both ends of the serial eeprom command port
// assumes a 40 MHz system clock on each end
package sep_pkg;
    // ************************************************************
    // geometry
    // ************************************************************
    localparam int ADDR_W   = 6;
    localparam int DATA_W   = 16;
    localparam int WORDS    = 64;
    // ************************************************************
    // opcodes
    // ************************************************************
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_MISC  = 2'h0;
    localparam logic [1:0] SUB_WEN  = 2'h3;
    localparam logic [1:0] SUB_LOCK = 2'h0;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ             = 40000000;
    localparam int PROGRAM_CYCLE_MS   = 25;
    localparam int PROGRAM_CYCLE_CYC  = PROGRAM_CYCLE_MS * (CLK_HZ / 1000);
    localparam int SK_HALF_NS         = 2000;
    localparam int SK_HALF_CYC        = (SK_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int CS_LOW_NS          = 1000;
    localparam int CS_LOW_CYC         = (CS_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [1:0] RST_BITS   = 2'h0;
    typedef enum logic [1:0] {
        SEP_CMD_READ,
        SEP_CMD_WRITE,
        SEP_CMD_WEN,
        SEP_CMD_LOCK
    } sep_cmd_t;
endpackage

/* File: hw/sep_link_if.sv */
// wires between the host end and the eeprom end
// assumes both ends run on one system clock domain each
`timescale 1ns/10ps
interface sep_link_if;
    logic chip_select;
    logic serial_shift_clock;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    modport dev (
        input  chip_select,
        input  serial_shift_clock,
        input  serial_in,
        output serial_out,
        output serial_out_oe
    );
    modport host (
        output chip_select,
        output serial_shift_clock,
        output serial_in,
        input  serial_out,
        input  serial_out_oe
    );
endinterface

/* File: hw/sep_device.sv */
// eeprom end: command sequencer, 64x16 array, program timer, output driver
// assumes link pins are asynchronous and resampled on clk
//
// Operation
// - sample data on each shift clock rise
// - host deselects between operations
// - first one after select is start
// - read shifts sixteen bits msb first
// - zero dummy bit on last address
// - continued clocking reads next words
// - power on leaves writes locked
// - enable persists until lock command
// - reads work whether locked or not
// - locked device ignores write commands
// - programming starts on deselect after 25th
// - status low busy, high ready
// - no commands accepted while busy
// - host holds data low during programming
// - deselect before end cancels write
// - programming cannot be aborted
// - deselect discards partial input
// - host keeps pins low in standby
// - status driven until next start bit
// - shared wire host keeps clock low
// - host locks after finishing writes
`timescale 1ns/10ps
module sep_device #(
    parameter int PROG_CYC = sep_pkg::PROGRAM_CYCLE_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    sep_link_if.dev   link,
    output logic      busy,
    output logic      write_enabled
);
    typedef enum logic [2:0] {
        SEP_IDLE, SEP_CMD, SEP_RDATA, SEP_WDATA, SEP_WAITCS, SEP_STATUS, SEP_HOLD
    } sep_dev_st_t;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] cs_sync;
    logic [1:0] sk_sync;
    logic [1:0] di_sync;
    logic       sk_prev;
    logic       cs_prev;
    logic       cs;
    logic       di;
    logic       sk_rise;
    logic       cs_fall;
    logic       cs_rise;

    // two flops per pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_sync <= sep_pkg::RST_BITS;
            sk_sync <= sep_pkg::RST_BITS;
            di_sync <= sep_pkg::RST_BITS;
            sk_prev <= 1'b0;
            cs_prev <= 1'b0;
        end else begin
            cs_sync <= {cs_sync[0], link.chip_select};
            sk_sync <= {sk_sync[0], link.serial_shift_clock};
            di_sync <= {di_sync[0], link.serial_in};
            sk_prev <= sk_sync[1];
            cs_prev <= cs_sync[1];
        end
    end
    assign cs      = cs_sync[1];
    assign di      = di_sync[1];
    assign sk_rise = sk_sync[1] & ~sk_prev & cs;
    assign cs_fall = cs_prev & ~cs;
    assign cs_rise = cs & ~cs_prev;

    // ************************************************************
    // sequencer
    // ************************************************************
    sep_dev_st_t               state;
    logic [8:0]                cmd;       // opcode and address
    logic [3:0]                cnt;
    logic [sep_pkg::ADDR_W-1:0] addr;
    logic [sep_pkg::DATA_W-1:0] shreg;
    logic [sep_pkg::DATA_W-1:0] mem [sep_pkg::WORDS];
    logic [31:0]               prog_cnt;
    logic                      prog_go;
    logic                      do_val;
    logic                      do_oe;

    // command decode, read shifting, write capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state   <= SEP_IDLE;
            cmd     <= '0;
            cnt     <= '0;
            addr    <= '0;
            shreg   <= '0;
            do_val  <= 1'b0;
            do_oe   <= 1'b0;
            prog_go <= 1'b0;
        end else begin
            prog_go <= 1'b0;
            if (!cs && state != SEP_WAITCS) begin
                state <= (busy || prog_go) ? SEP_STATUS : SEP_IDLE;
                do_oe <= 1'b0;
            end else if (cs_fall && state == SEP_WAITCS) begin
                state   <= SEP_STATUS;
                prog_go <= 1'b1;
            end else if (cs_rise && state == SEP_STATUS) begin
                do_oe  <= 1'b1;
                do_val <= ~busy;
            end else begin
                case (state)
                    SEP_IDLE, SEP_STATUS: begin
                        if (state == SEP_STATUS) begin
                            do_val <= ~busy;
                        end
                        if (sk_rise && di && !busy) begin
                            state <= SEP_CMD;
                            cnt   <= '0;
                            do_oe <= 1'b0;
                        end
                    end
                    SEP_CMD: begin
                        if (sk_rise) begin
                            cmd <= {cmd[7:0], di};
                            cnt <= cnt + 4'h1;
                            if (cnt == 4'h7) begin
                                addr <= {cmd[4:0], di};
                                cnt  <= '0;
                                case (cmd[6:5])
                                    sep_pkg::OP_READ: begin
                                        state  <= SEP_RDATA;
                                        shreg  <= mem[{cmd[4:0], di}];
                                        do_oe  <= 1'b1;
                                        do_val <= 1'b0;
                                    end
                                    sep_pkg::OP_WRITE: begin
                                        state <= write_enabled ? SEP_WDATA : SEP_HOLD;
                                    end
                                    default: begin
                                        state <= SEP_HOLD;   // wait for deselect
                                    end
                                endcase
                            end
                        end
                    end
                    SEP_RDATA: begin
                        if (sk_rise) begin
                            do_val <= shreg[sep_pkg::DATA_W-1];
                            shreg  <= {shreg[sep_pkg::DATA_W-2:0], 1'b0};
                            cnt    <= cnt + 4'h1;
                            if (cnt == 4'hf) begin
                                addr  <= addr + 6'h1;
                                shreg <= mem[addr + 6'h1];
                            end
                        end
                    end
                    SEP_WDATA: begin
                        if (sk_rise) begin
                            shreg <= {shreg[sep_pkg::DATA_W-2:0], di};
                            cnt   <= cnt + 4'h1;
                            if (cnt == 4'hf) begin
                                state <= SEP_WAITCS;
                            end
                        end
                    end
                    SEP_HOLD: begin
                        state <= SEP_HOLD;                 // data bits never seen as starts
                    end
                    SEP_WAITCS: begin
                        do_oe <= 1'b0;
                    end
                    default: begin
                        state <= SEP_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // write enable latch
    // ************************************************************
    // cleared by reset, changed only by enable or lock commands
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_enabled <= 1'b0;
        end else if (state == SEP_CMD && sk_rise && cs && cnt == 4'h7
                     && cmd[6:5] == sep_pkg::OP_MISC) begin
            if (cmd[4:3] == sep_pkg::SUB_WEN) begin
                write_enabled <= 1'b1;
            end else if (cmd[4:3] == sep_pkg::SUB_LOCK) begin
                write_enabled <= 1'b0;
            end
        end
    end

    // ************************************************************
    // program timer and array update
    // ************************************************************
    // runs to the end regardless of pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy     <= 1'b0;
            prog_cnt <= '0;
        end else if (prog_go) begin
            busy     <= 1'b1;
            prog_cnt <= 32'(PROG_CYC - 1);
        end else if (busy) begin
            if (prog_cnt == 32'h0) begin
                busy <= 1'b0;
            end else begin
                prog_cnt <= prog_cnt - 32'h1;
            end
        end
    end

    // array written at programming start
    always_ff @(posedge clk) begin
        if (prog_go) begin
            mem[addr] <= shreg;
        end
    end

    assign link.serial_out    = do_oe ? do_val : 1'b1;   // released line reads as pulled high
    assign link.serial_out_oe = do_oe;
endmodule

/* File: hw/sep_host.sv */
// host end: runs one command per request, buffers read words
// assumes device pins reach it asynchronously
`timescale 1ns/10ps
module sep_host (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    sep_link_if.host                        link,
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire sep_pkg::sep_cmd_t          req_cmd,
    input  wire logic [sep_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [sep_pkg::DATA_W-1:0] req_data,
    output logic                            rd_valid,
    input  wire logic                       rd_ready,
    output logic [sep_pkg::DATA_W-1:0]      rd_data,
    output logic                            done
);
    typedef enum logic [2:0] {
        SEH_IDLE, SEH_SHIFT, SEH_READ, SEH_GAP, SEH_POLL
    } sep_host_st_t;

    // ************************************************************
    // synchronisers and shift clock divider
    // ************************************************************
    logic [1:0]  do_sync;
    logic [7:0]  div;
    logic        tick;
    sep_host_st_t state;
    logic [24:0] sh;
    logic [4:0]  nbits;
    logic [15:0] rword;
    logic        is_write;
    logic        is_read;
    logic [7:0]  gap;
    logic        buf_ready;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            do_sync <= sep_pkg::RST_BITS;
        end else begin
            do_sync <= {do_sync[0], link.serial_out};
        end
    end

    // one enable per half period of the shift clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div <= '0;
        end else begin
            div <= (div == 8'(sep_pkg::SK_HALF_CYC - 1)) ? 8'h0 : div + 8'h1;
        end
    end
    assign tick      = (div == 8'(sep_pkg::SK_HALF_CYC - 1));
    assign req_ready = (state == SEH_IDLE);

    // ************************************************************
    // command sequencer
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state                   <= SEH_IDLE;
            link.chip_select        <= 1'b0;   // standby low
            link.serial_shift_clock <= 1'b0;
            link.serial_in          <= 1'b0;
            sh       <= '0;
            nbits    <= '0;
            rword    <= '0;
            is_write <= 1'b0;
            is_read  <= 1'b0;
            gap      <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                SEH_IDLE: begin
                    if (req_valid) begin
                        is_write <= (req_cmd == sep_pkg::SEP_CMD_WRITE);
                        is_read  <= (req_cmd == sep_pkg::SEP_CMD_READ);
                        case (req_cmd)
                            sep_pkg::SEP_CMD_READ:
                                sh <= {1'b1, sep_pkg::OP_READ, req_addr, 16'h0};
                            sep_pkg::SEP_CMD_WRITE:
                                sh <= {1'b1, sep_pkg::OP_WRITE, req_addr, req_data};
                            sep_pkg::SEP_CMD_WEN:
                                sh <= {1'b1, sep_pkg::OP_MISC, sep_pkg::SUB_WEN, 4'h0, 16'h0};
                            default:
                                sh <= {1'b1, sep_pkg::OP_MISC, sep_pkg::SUB_LOCK, 4'h0, 16'h0};
                        endcase
                        nbits            <= (req_cmd == sep_pkg::SEP_CMD_WRITE) ? 5'd25 : 5'd9;
                        link.chip_select <= 1'b1;
                        state            <= SEH_SHIFT;
                    end
                end
                SEH_SHIFT: begin
                    if (tick) begin
                        link.serial_shift_clock <= ~link.serial_shift_clock;
                        if (link.serial_shift_clock) begin
                            if (nbits == 5'd0) begin
                                link.serial_in <= 1'b0;
                                state <= is_read ? SEH_READ : SEH_GAP;
                                nbits <= 5'd17;   // dummy bit, then sixteen data bits
                                link.serial_shift_clock <= is_read;
                            end else begin
                                link.serial_in <= sh[24];
                                sh    <= {sh[23:0], 1'b0};
                                nbits <= nbits - 5'd1;
                            end
                        end
                    end
                end
                SEH_READ: begin
                    // rising edges shift the word out
                    if (tick && buf_ready) begin
                        link.serial_shift_clock <= ~link.serial_shift_clock;
                        if (!link.serial_shift_clock) begin
                            rword <= {rword[14:0], do_sync[1]};
                            nbits <= nbits - 5'd1;
                        end else if (nbits == 5'd0) begin
                            link.serial_shift_clock <= 1'b0;
                            state <= SEH_GAP;
                        end
                    end
                end
                SEH_GAP: begin
                    // deselect between operations
                    link.chip_select <= 1'b0;
                    link.serial_in   <= 1'b0;
                    // count system clocks, leave on a tick so polling starts aligned
                    if (gap != 8'(sep_pkg::CS_LOW_CYC)) begin
                        gap <= gap + 8'h1;
                    end else if (tick) begin
                        gap <= '0;
                        if (is_write) begin
                            link.chip_select <= 1'b1; // clock held low
                            state <= SEH_POLL;
                        end else begin
                            done  <= 1'b1;
                            state <= SEH_IDLE;
                        end
                    end
                end
                SEH_POLL: begin
                    // data low, clock still, wait for ready
                    if (tick && do_sync[1]) begin
                        link.chip_select <= 1'b0;
                        is_write <= 1'b0;                 // full deselect gap before done
                        state <= SEH_GAP;
                    end
                end
                default: begin
                    state <= SEH_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // two entry read buffer
    // ************************************************************
    logic [15:0] bufm [2];
    logic [1:0]  fill;
    logic        wptr;
    logic        rptr;
    logic        push;
    logic        pop;
    assign buf_ready = (fill != 2'd2);
    assign push      = (state == SEH_READ) && tick && buf_ready
                       && link.serial_shift_clock && nbits == 5'd0;
    assign pop       = rd_valid && rd_ready;
    assign rd_valid  = (fill != 2'd0);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fill <= '0;
            wptr <= 1'b0;
            rptr <= 1'b0;
        end else begin
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            bufm[wptr] <= rword;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (pop || fill == 2'd0) begin
            rd_data <= push && (fill == 2'd0 || fill == 2'd1 && pop) ? rword : bufm[~rptr];
        end
    end
endmodule

/* File: verification/sep_link_assertions.sv */
// checker for the link between host end and eeprom end
// assumes one clk domain with active-low reset rstn
`timescale 1ns/10ps
module sep_link_assertions #(
    parameter int PROG_CYC = 200
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic chip_select,
    input wire logic serial_shift_clock,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic busy,
    input wire logic write_enabled
);
    int busy_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // length of the current busy stretch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy ? busy_cnt + 1 : 0;
        end
    end
    // ************************************************************
    // assertions
    // ************************************************************
    a_status_shows_busy: assert property (chip_select && serial_out_oe && busy &&
        $past(busy, 4) |-> !serial_out) else $error("status not low while busy");
    a_busy_full_length: assert property ($fell(busy) |->
        busy_cnt >= PROG_CYC - 1 && busy_cnt <= PROG_CYC + 1) else $error("bad busy length");
    a_enable_by_cmd: assert property ($changed(write_enabled) |->
        $past(chip_select)) else $error("enable latch moved while deselected");
    a_prog_on_deselect: assert property ($rose(busy) |->
        !chip_select && write_enabled) else $error("programming started wrongly");
    a_busy_refuses_cmd: assert property (busy && $past(busy) |->
        $stable(write_enabled)) else $error("command taken while busy");
    a_out_released: assert property ((!chip_select)[*6] |->
        !serial_out_oe) else $error("output driven while deselected");
    a_clock_idle_low: assert property (!chip_select |->
        !serial_shift_clock) else $error("shift clock high while deselected");
    a_data_low_busy: assert property (chip_select && serial_out_oe && busy |->
        !serial_in) else $error("data input high while polling busy");
    a_deselect_gap: assert property ($fell(chip_select) |->
        (!chip_select)[*8]) else $error("deselect gap too short");
    // main scenarios
    c_program: cover property ($rose(busy));
    c_lock: cover property ($fell(write_enabled));
    c_status: cover property (chip_select && serial_out_oe && busy);
endmodule

/* File: verification/testbench.sv */
// bench: host end and eeprom end joined by the link interface
// assumes sep_pkg, the interface, both ends and the checker compiled first
`timescale 1ns/10ps
module testbench;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int PROG = 200;
    logic                       clk;
    logic                       rstn;
    logic                       host_rstn;
    logic                       req_valid;
    logic                       req_ready;
    sep_pkg::sep_cmd_t          req_cmd;
    logic [sep_pkg::ADDR_W-1:0] req_addr;
    logic [sep_pkg::DATA_W-1:0] req_data;
    logic                       rd_valid;
    logic                       rd_ready;
    logic [sep_pkg::DATA_W-1:0] rd_data;
    logic                       done;
    logic                       busy;
    logic                       write_enabled;
    logic                       saw_busy;
    int                         errors;
    int                         comparisons;
    int                         cycles;
    sep_link_if u_sep_link_if ();
    sep_device #(.PROG_CYC(PROG)) u_sep_device (.clk(clk), .rstn(rstn), .link(u_sep_link_if),
        .busy(busy), .write_enabled(write_enabled));
    sep_host u_sep_host (.clk(clk), .rstn(host_rstn), .link(u_sep_link_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
        .req_data(req_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .done(done));
    sep_link_assertions #(.PROG_CYC(PROG)) u_sep_link_assertions (.clk(clk), .rstn(rstn),
        .chip_select(u_sep_link_if.chip_select), .serial_in(u_sep_link_if.serial_in),
        .serial_shift_clock(u_sep_link_if.serial_shift_clock),
        .serial_out(u_sep_link_if.serial_out), .serial_out_oe(u_sep_link_if.serial_out_oe),
        .busy(busy), .write_enabled(write_enabled));
    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // busy seen since last clear, and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (busy === 1'b1) saw_busy <= 1'b1;
        if (cycles == 90000) begin
            errors = errors + 1;
            results();
        end
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_neg(ref logic sig, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sig !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (sig !== lvl) begin
            errors = errors + 1;
            results();
        end
    endtask
    task automatic send(input sep_pkg::sep_cmd_t c, input logic [5:0] a, input logic [15:0] d,
                        input bit wait_done);
        @(negedge clk);
        wait_neg(req_ready, 1'b1, 20000);
        @(posedge clk);
        saw_busy <= 1'b0;
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        req_data <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        if (wait_done) wait_neg(done, 1'b1, 20000);
    endtask
    task automatic pop(input logic [15:0] exp);
        @(negedge clk);
        wait_neg(rd_valid, 1'b1, 20000);
        check("rd_data", exp, rd_data);
        @(posedge clk);
        rd_ready <= 1'b1;
        @(posedge clk);
        rd_ready <= 1'b0;
    endtask
    task automatic host_reset();
        @(posedge clk);
        host_rstn <= 1'b0;
        repeat (2) @(posedge clk);
        host_rstn <= 1'b1;
    endtask
    task automatic results();
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_power_on();
        check("write_enabled", 16'h0000, {15'h0000, write_enabled});
        send(sep_pkg::SEP_CMD_WRITE, 6'h05, 16'h1234, 1'b1);
        check("saw_busy", 16'h0000, {15'h0000, saw_busy});
    endtask
    task automatic t_enable_write();
        logic [5:0]  addrs [3];
        logic [15:0] vals [3];
        addrs = '{6'h00, 6'h3f, 6'h05};
        vals = '{16'h8001, 16'h7ffe, 16'ha5a5};
        send(sep_pkg::SEP_CMD_WEN, 6'h30, 16'h0000, 1'b1);
        check("write_enabled", 16'h0001, {15'h0000, write_enabled});
        for (int i = 0; i < 3; i++) begin
            send(sep_pkg::SEP_CMD_WRITE, addrs[i], vals[i], 1'b1);
            check("saw_busy", 16'h0001, {15'h0000, saw_busy});
        end
        check("write_enabled", 16'h0001, {15'h0000, write_enabled});
    endtask
    // two reads left unpopped, so the buffer holds both
    task automatic t_read_back();
        send(sep_pkg::SEP_CMD_READ, 6'h3f, 16'h0000, 1'b1);
        send(sep_pkg::SEP_CMD_READ, 6'h00, 16'h0000, 1'b1);
        pop(16'h7ffe);
        pop(16'h8001);
    endtask
    task automatic t_lock_ignores();
        send(sep_pkg::SEP_CMD_LOCK, 6'h00, 16'h0000, 1'b1);
        check("write_enabled", 16'h0000, {15'h0000, write_enabled});
        send(sep_pkg::SEP_CMD_WRITE, 6'h05, 16'h5a5a, 1'b1);
        check("saw_busy", 16'h0000, {15'h0000, saw_busy});
        send(sep_pkg::SEP_CMD_READ, 6'h05, 16'h0000, 1'b1);
        pop(16'ha5a5);
    endtask
    // deselect mid data phase, then deselect during programming
    task automatic t_cancel_and_no_abort();
        send(sep_pkg::SEP_CMD_WEN, 6'h3c, 16'h0000, 1'b1);
        send(sep_pkg::SEP_CMD_WRITE, 6'h05, 16'hffff, 1'b0);
        repeat (2000) @(posedge clk);
        host_reset();
        repeat (PROG + 500) @(posedge clk);
        check("saw_busy", 16'h0000, {15'h0000, saw_busy});
        send(sep_pkg::SEP_CMD_READ, 6'h05, 16'h0000, 1'b1);
        pop(16'ha5a5);
        send(sep_pkg::SEP_CMD_WRITE, 6'h05, 16'h0f0f, 1'b0);
        wait_neg(busy, 1'b1, 8000);
        host_reset();
        wait_neg(busy, 1'b0, 2 * PROG);
        send(sep_pkg::SEP_CMD_READ, 6'h05, 16'h0000, 1'b1);
        pop(16'h0f0f);
        send(sep_pkg::SEP_CMD_LOCK, 6'h0f, 16'h0000, 1'b1);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rstn = 1'b0;
        host_rstn = 1'b0;
        req_valid = 1'b0;
        req_cmd = sep_pkg::SEP_CMD_READ;
        req_addr = 6'h00;
        req_data = 16'h0000;
        rd_ready = 1'b0;
        saw_busy = 1'b0;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        host_rstn <= 1'b1;
        t_power_on();
        t_enable_write();
        t_read_back();
        t_lock_ignores();
        t_cancel_and_no_abort();
        results();
    end
endmodule
